// File: include/pbs_cfg.svh
// constants of the pipelined burst sram control block
// assumes a 20 mhz clock on clk
`ifndef PBS_CFG_SVH
`define PBS_CFG_SVH

`define PBS_ADDR_W          17
`define PBS_LO_W            2
`define PBS_DATA_W          16
`define PBS_LANES           2
`define PBS_LANE_BITS       8
`define PBS_FIFO_DEPTH      8
`define PBS_CLK_NS          50
`define PBS_SLEEP_ENTER_NS  100
`define PBS_SLEEP_ENTER_CYC (`PBS_SLEEP_ENTER_NS / `PBS_CLK_NS)
`define PBS_SLEEP_REC_NS    100
`define PBS_SLEEP_REC_CYC   ((`PBS_SLEEP_REC_NS + `PBS_CLK_NS - 1) / `PBS_CLK_NS)
`define PBS_BEAT_RST        2'h0
`define PBS_BEAT_STEP       2'h1
`define PBS_MODE_LINEAR_RST 1'b0
`define PBS_MASK_ALL        2'h3
`define PBS_MASK_NONE       2'h0

`endif

// File: include/pbs_pkg.sv
// types of the pipelined burst sram control block
// assumes pbs_cfg.svh on the include path
`default_nettype none

package pbs_pkg;
	`include "pbs_cfg.svh"

	typedef logic [`PBS_ADDR_W-1:0]             pbs_addr_t;
	typedef logic [`PBS_LO_W-1:0]               pbs_lo_t;
	typedef logic [`PBS_DATA_W-1:0]             pbs_data_t;
	typedef logic [`PBS_LANES-1:0]              pbs_mask_t;
	// word layout: parity bits above data, lane i owns data byte i and parity bit i
	typedef logic [`PBS_DATA_W+`PBS_LANES-1:0]  pbs_word_t;

	typedef enum logic [2:0] {
		PBS_ACC_IDLE  = 3'h1,
		PBS_ACC_READ  = 3'h2,
		PBS_ACC_WRITE = 3'h4
	} pbs_acc_e;

	typedef struct packed {
		pbs_addr_t addr;
		pbs_word_t word;
		pbs_mask_t mask;
	} pbs_wreq_s;

	typedef struct packed {
		logic                            sleep_s1;
		logic                            sleep_s2;
		logic                            mode_taken;
		logic                            mode_linear;
		logic                            active;
		logic [`PBS_ADDR_W-`PBS_LO_W-1:0] addr_hi;
		pbs_lo_t                         start_lo;
		pbs_lo_t                         beat;
		pbs_acc_e                        acc;
		pbs_addr_t                       rd_addr;
		logic                            out_live;
		pbs_word_t                       dout;
	} pbs_ctrl_s;
endpackage

`default_nettype wire

// File: design/pbs_fifo.sv
// write request buffer, show-ahead, valid and ready on both sides
// assumes depth is a power of two
`timescale 1ns/1ps
`default_nettype none

module pbs_fifo #(
	parameter int WIDTH = 37,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [PW-1:0] wr_ptr;
		logic [PW-1:0] rd_ptr;
		logic [PW:0]   count;
	} pbs_fifo_s;

	pbs_fifo_s        st;
	pbs_fifo_s        next_st;
	logic [WIDTH-1:0] store [DEPTH];
	logic             push;
	logic             pop;

	// ----------------------------------------
	// flags
	// ----------------------------------------
	assign in_ready  = st.count != (PW+1)'(DEPTH);
	assign out_valid = st.count != '0;
	assign out_data  = store[st.rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// ----------------------------------------
	// pointers
	// ----------------------------------------
	always_comb begin
		next_st = st;
		if (push) begin
			next_st.wr_ptr = PW'(st.wr_ptr + 1'b1);
		end
		if (pop) begin
			next_st.rd_ptr = PW'(st.rd_ptr + 1'b1);
		end
		case ({push, pop})
			2'h2: next_st.count = (PW+1)'(st.count + 1'b1);
			2'h1: next_st.count = (PW+1)'(st.count - 1'b1);
			default: next_st.count = st.count;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			store[st.wr_ptr] <= in_data;
		end
	end
endmodule

`default_nettype wire

// File: design/pbs_sram_ctrl.sv
// control logic and array of a pipelined burst sram with common data i/o
// assumes all synchronous inputs meet setup to clk; sleep_request may be asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "pbs_cfg.svh"

module pbs_sram_ctrl (
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire pbs_pkg::pbs_addr_t address,
	input  wire logic              processor_address_strobe_n,
	input  wire logic              controller_address_strobe_n,
	input  wire logic              burst_advance_n,
	input  wire logic              chip_select_primary_n,
	input  wire logic              chip_select_depth_high,
	input  wire logic              chip_select_depth_low_n,
	input  wire logic              global_write_n,
	input  wire logic              byte_write_enable_n,
	input  wire pbs_pkg::pbs_mask_t byte_lane_write_n,
	input  wire logic              output_drive_enable_n,
	input  wire logic              sleep_request,
	input  wire logic              burst_order_strap,
	input  wire pbs_pkg::pbs_data_t data_lines_in,
	output pbs_pkg::pbs_data_t      data_lines_out,
	output logic                   data_lines_oe,
	input  wire pbs_pkg::pbs_mask_t parity_lines_in,
	output pbs_pkg::pbs_mask_t      parity_lines_out,
	output logic                   parity_lines_oe,
	output logic                   write_buffer_ready
);
	import pbs_pkg::*;

	localparam int SLP_MAX = `PBS_SLEEP_ENTER_CYC;

	pbs_ctrl_s st;
	pbs_ctrl_s next_st;
	pbs_word_t mem [1 << `PBS_ADDR_W];

	logic      sel;
	logic      any_wr;
	logic      processor_address_strobe_go;
	logic      controller_address_strobe_go;
	logic      start_rd;
	logic      start_wr;
	logic      desel;
	logic      cont;
	logic      burst_advance;
	logic      write_det;
	logic      write_now;
	logic      dq_oe;
	pbs_lo_t   cur_lo;
	pbs_lo_t   acc_lo;
	pbs_addr_t acc_addr;
	pbs_wreq_s wreq;
	pbs_wreq_s fifo_out;
	logic      fifo_out_valid;
	logic      fifo_out_ready;
	pbs_word_t rd_word;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic pbs_lo_t burst_lo(input pbs_lo_t start, input pbs_lo_t beat, input logic linear);
		if (linear) begin
			return pbs_lo_t'(start + beat);
		end
		return start ^ beat;
	endfunction

	function automatic pbs_word_t merge_word(input pbs_word_t old, input pbs_word_t nw, input pbs_mask_t mask);
		pbs_word_t w;
		w = old;
		for (int i = 0; i < `PBS_LANES; i++) begin
			if (mask[i]) begin
				w[i*`PBS_LANE_BITS +: `PBS_LANE_BITS] = nw[i*`PBS_LANE_BITS +: `PBS_LANE_BITS];
				w[`PBS_DATA_W+i] = nw[`PBS_DATA_W+i];
			end
		end
		return w;
	endfunction

	// ----------------------------------------
	// cycle decode
	// ----------------------------------------
	assign sel      = !chip_select_primary_n && chip_select_depth_high && !chip_select_depth_low_n;
	assign any_wr   = !global_write_n || (!byte_write_enable_n && !(&byte_lane_write_n));
	assign processor_address_strobe_go  = !processor_address_strobe_n && !chip_select_primary_n;
	assign controller_address_strobe_go  = !controller_address_strobe_n && !processor_address_strobe_go;
	assign start_rd = sel && (processor_address_strobe_go || (controller_address_strobe_go && !any_wr));
	assign start_wr = sel && controller_address_strobe_go && any_wr;
	assign desel    = (processor_address_strobe_go || controller_address_strobe_go) && !sel;
	assign cont     = !processor_address_strobe_go && !controller_address_strobe_go && st.active && !st.sleep_s2;
	assign burst_advance      = cont && !burst_advance_n;
	assign write_det = start_wr || (cont && any_wr);
	assign write_now = write_det && !st.sleep_s2;

	assign cur_lo   = burst_lo(st.start_lo, st.beat, st.mode_linear);
	assign acc_lo   = burst_advance ? burst_lo(st.start_lo, pbs_lo_t'(st.beat + `PBS_BEAT_STEP), st.mode_linear) : cur_lo;
	assign acc_addr = start_wr ? address : {st.addr_hi, acc_lo};

	// ----------------------------------------
	// write path through the buffer
	// ----------------------------------------
	always_comb begin
		wreq.addr = acc_addr;
		wreq.word = {parity_lines_in, data_lines_in};
		if (!global_write_n) begin
			wreq.mask = `PBS_MASK_ALL;
		end else if (!byte_write_enable_n) begin
			wreq.mask = ~byte_lane_write_n;
		end else begin
			wreq.mask = `PBS_MASK_NONE;
		end
	end

	assign fifo_out_ready = !st.sleep_s2;

	pbs_fifo #(
		.WIDTH ($bits(pbs_wreq_s)),
		.DEPTH (`PBS_FIFO_DEPTH)
	) u_pbs_fifo (
		.clk       (clk),
		.rstn      (rstn),
		.in_valid  (write_now),
		.in_ready  (write_buffer_ready),
		.in_data   (wreq),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out)
	);

	always_ff @(posedge clk) begin
		if (fifo_out_valid && fifo_out_ready) begin
			mem[fifo_out.addr] <= merge_word(mem[fifo_out.addr], fifo_out.word, fifo_out.mask);
		end
	end

	// read sees a write still waiting at the buffer head
	always_comb begin
		rd_word = mem[st.rd_addr];
		if (fifo_out_valid && fifo_out.addr == st.rd_addr) begin
			rd_word = merge_word(rd_word, fifo_out.word, fifo_out.mask);
		end
	end

	// ----------------------------------------
	// control state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		next_st.sleep_s1 = sleep_request;
		next_st.sleep_s2 = st.sleep_s1;
		if (!st.mode_taken) begin
			next_st.mode_taken  = 1'b1;
			next_st.mode_linear = !burst_order_strap;
		end
		case (st.acc)
			PBS_ACC_READ: begin
				next_st.out_live = 1'b1;
				next_st.dout     = rd_word;
			end
			default: begin
				next_st.out_live = 1'b0;
			end
		endcase
		next_st.acc = PBS_ACC_IDLE;
		if (st.sleep_s2) begin
			next_st.out_live = 1'b0;
		end else if (processor_address_strobe_go || controller_address_strobe_go) begin
			if (sel) begin
				next_st.active   = 1'b1;
				next_st.addr_hi  = address[`PBS_ADDR_W-1:`PBS_LO_W];
				next_st.start_lo = address[`PBS_LO_W-1:0];
				next_st.beat     = `PBS_BEAT_RST;
				next_st.rd_addr  = address;
				next_st.acc      = start_wr ? PBS_ACC_WRITE : PBS_ACC_READ;
			end else begin
				next_st.active = 1'b0;
			end
		end else if (cont) begin
			if (burst_advance) begin
				next_st.beat = pbs_lo_t'(st.beat + `PBS_BEAT_STEP);
			end
			next_st.rd_addr = acc_addr;
			next_st.acc     = any_wr ? PBS_ACC_WRITE : PBS_ACC_READ;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st             <= '0;
			st.beat        <= `PBS_BEAT_RST;
			st.mode_linear <= `PBS_MODE_LINEAR_RST;
			st.acc         <= PBS_ACC_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// data pins
	// ----------------------------------------
	assign dq_oe = st.out_live && !output_drive_enable_n && !write_det && !sleep_request && !st.sleep_s2;
	assign data_lines_out   = st.dout[`PBS_DATA_W-1:0];
	assign parity_lines_out = st.dout[`PBS_DATA_W+`PBS_LANES-1:`PBS_DATA_W];
	assign data_lines_oe    = dq_oe;
	assign parity_lines_oe  = dq_oe;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	write_tristate_a: assert property (write_det |-> !data_lines_oe && !parity_lines_oe)
		else $error("data pins driven during a write cycle");
	sleep_quiet_a: assert property (sleep_request |-> !data_lines_oe && !parity_lines_oe)
		else $error("data pins driven while sleep is requested");
	sleep_enter_a: assert property ($rose(sleep_request) ##1 sleep_request |-> ##[0:1] st.sleep_s2)
		else $error("sleep not entered within two cycles");
	sleep_exit_a: assert property ($fell(sleep_request) ##1 !sleep_request |-> ##[0:1] !st.sleep_s2)
		else $error("sleep not left within two cycles");
	sleep_bound_a: assert property ($rose(st.sleep_s2) |-> $past(sleep_request, SLP_MAX))
		else $error("sleep entered without a request two cycles before");
	processor_address_strobe_no_write_a: assert property (processor_address_strobe_go && sel && !st.sleep_s2 |-> !write_now ##1 st.acc == PBS_ACC_READ)
		else $error("write taken on a processor strobe start");
	controller_address_strobe_write_a: assert property (start_wr && write_buffer_ready && !st.sleep_s2 |=>
		fifo_out_valid && fifo_out.addr == $past(address))
		else $error("controller strobe write not queued at its address");
	global_mask_a: assert property (write_now && write_buffer_ready && !global_write_n |=>
		fifo_out_valid && fifo_out.mask == `PBS_MASK_ALL)
		else $error("global write does not select every lane");
	interleave_a: assert property (burst_advance && !st.mode_linear |=>
		cur_lo == ($past(cur_lo) ^ $past(st.beat) ^ pbs_lo_t'($past(st.beat) + 2'h1)))
		else $error("interleaved burst step wrong");
	linear_a: assert property (burst_advance && st.mode_linear |=> cur_lo == $past(cur_lo) + 2'h1)
		else $error("linear burst step wrong");
	suspend_a: assert property (cont && burst_advance_n |=> cur_lo == $past(cur_lo))
		else $error("suspended burst moved its address");
	cs_ignore_a: assert property (!processor_address_strobe_n && chip_select_primary_n &&
		controller_address_strobe_n && !st.active |=> !st.active)
		else $error("processor strobe honoured with primary select high");
	read_latency_a: assert property (start_rd && !st.sleep_s2 && !st.sleep_s1 |=> ##1 st.out_live)
		else $error("read data not ready one cycle after capture");
	first_read_a: assert property (!st.active && start_rd |=> !data_lines_oe)
		else $error("first read after deselect drives the pins");
	dcd_a: assert property (desel && st.acc == PBS_ACC_READ && !st.sleep_s2 && !st.sleep_s1 |=>
		st.out_live ##1 !st.out_live)
		else $error("deselect did not give one more drive cycle");

	cover property (burst_advance && !st.mode_linear ##1 burst_advance ##1 burst_advance);
	cover property (burst_advance && st.mode_linear ##1 burst_advance ##1 burst_advance);
	cover property (start_wr && byte_write_enable_n == 1'b0 && global_write_n);
	cover property ($rose(st.sleep_s2) ##[1:20] $fell(st.sleep_s2));
	cover property (desel && st.out_live && dq_oe);
endmodule

`default_nettype wire

// File: tb/pbs_bus_master.sv
// bus master model: strobes, selects, write controls, output enable, write data, sleep
// assumes the bench calls put once a cycle, just after a falling clock edge
`timescale 1ns/1ps
`default_nettype none

module pbs_bus_master (
	output pbs_pkg::pbs_addr_t address,
	output logic               processor_address_strobe_n,
	output logic               controller_address_strobe_n,
	output logic               burst_advance_n,
	output logic               chip_select_primary_n,
	output logic               chip_select_depth_high,
	output logic               chip_select_depth_low_n,
	output logic               global_write_n,
	output logic               byte_write_enable_n,
	output pbs_pkg::pbs_mask_t byte_lane_write_n,
	output logic               output_drive_enable_n,
	output logic               sleep_request,
	output pbs_pkg::pbs_word_t wdata
);
	import pbs_pkg::*;

	// --------------------------------------------------------------
	// one bus cycle
	// --------------------------------------------------------------
	task automatic put(input logic [5:0] ctl, input logic [3:0] wr, input pbs_addr_t a, input pbs_word_t d);
		logic act;
		act = !wr[3] || (!wr[2] && !(&wr[1:0]));
		output_drive_enable_n = act;
		{processor_address_strobe_n, controller_address_strobe_n, burst_advance_n} = ctl[5:3];
		{chip_select_primary_n, chip_select_depth_high, chip_select_depth_low_n} = ctl[2:0];
		{global_write_n, byte_write_enable_n, byte_lane_write_n} = wr;
		address = a;
		// released data lines toggle so a stale value is never seen
		wdata = act ? d : ~wdata;
	endtask

	// --------------------------------------------------------------
	// sleep entry and exit
	// --------------------------------------------------------------
	task automatic nap(input logic on);
		if (on) put(6'b101101, 4'hf, address, wdata);
		sleep_request = on;
		if (!on) put(6'b111101, 4'hf, address, wdata);
	endtask

	initial begin
		wdata = '0;
		sleep_request = 1'b0;
		put(6'b111101, 4'hf, '0, '0);
	end
endmodule

`default_nettype wire

// File: tb/tb_pbs_sram_ctrl.sv
// self-checking bench of the sram control block
// assumes the bus master model drives every bus input
`timescale 1ns/1ps
`default_nettype none
`include "pbs_cfg.svh"

module tb_pbs_sram_ctrl;
	import pbs_pkg::*;

	localparam logic [5:0] DES = 6'b101101;
	localparam logic [5:0] IDL = 6'b111101;

	logic      clk = 1'b0;
	logic      rstn = 1'b0;
	logic      burst_order_strap = 1'b1;
	pbs_addr_t address;
	logic      processor_address_strobe_n, controller_address_strobe_n, burst_advance_n;
	logic      chip_select_primary_n, chip_select_depth_high, chip_select_depth_low_n;
	logic      global_write_n, byte_write_enable_n, output_drive_enable_n, sleep_request;
	pbs_mask_t byte_lane_write_n, parity_lines_out;
	pbs_data_t data_lines_out;
	pbs_word_t wdata, mem [pbs_addr_t];
	logic      data_lines_oe, parity_lines_oe, write_buffer_ready;
	int        error_cnt = 0;
	int        n_compared = 0;

	always #25 clk = ~clk;

	pbs_bus_master u_pbs_bus_master (.address, .processor_address_strobe_n, .controller_address_strobe_n,
		.burst_advance_n, .chip_select_primary_n, .chip_select_depth_high, .chip_select_depth_low_n,
		.global_write_n, .byte_write_enable_n, .byte_lane_write_n, .output_drive_enable_n, .sleep_request, .wdata);

	pbs_sram_ctrl u_pbs_sram_ctrl (.clk, .rstn, .address, .processor_address_strobe_n,
		.controller_address_strobe_n, .burst_advance_n, .chip_select_primary_n, .chip_select_depth_high,
		.chip_select_depth_low_n, .global_write_n, .byte_write_enable_n, .byte_lane_write_n,
		.output_drive_enable_n, .sleep_request, .burst_order_strap,
		.data_lines_in(data_lines_oe ? data_lines_out : wdata[15:0]), .data_lines_out, .data_lines_oe,
		.parity_lines_in(parity_lines_oe ? parity_lines_out : wdata[17:16]), .parity_lines_out,
		.parity_lines_oe, .write_buffer_ready);

	// --------------------------------------------------------------
	// checking and stimulus helpers
	// --------------------------------------------------------------
	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string nm, input pbs_word_t seen, input pbs_word_t exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	function automatic pbs_word_t mrg(pbs_word_t o, pbs_word_t d, logic [3:0] wr);
		mrg = o;
		for (int i = 0; i < 2; i++)
			if (!wr[3] || (!wr[2] && !wr[i])) begin
				mrg[8*i +: 8] = d[8*i +: 8];
				mrg[16+i] = d[16+i];
			end
	endfunction

	task automatic step(input logic [5:0] ctl, input logic [3:0] wr, input pbs_addr_t a, input pbs_word_t d);
		@(negedge clk);
		u_pbs_bus_master.put(ctl, wr, a, d);
	endtask

	task automatic look(input logic eo, input pbs_word_t ew);
		#1;
		chk("data enable", pbs_word_t'(data_lines_oe), pbs_word_t'(eo));
		chk("parity enable", pbs_word_t'(parity_lines_oe), pbs_word_t'(eo));
		if (eo) chk("read word", {parity_lines_out, data_lines_out}, ew);
		chk("buffer ready", pbs_word_t'(write_buffer_ready), pbs_word_t'(1'b1));
	endtask

	task automatic wr_controller_address_strobe(input pbs_addr_t a, input logic [3:0] wr);
		pbs_word_t d;
		d = pbs_word_t'($urandom);
		step({2'b10, 1'($urandom), 3'b010}, wr, a, d);
		mem[a] = mrg(mem[a], d, wr);
	endtask

	task automatic burst(input pbs_addr_t a);
		pbs_addr_t cur, lag;
		logic [1:0] bt;
		logic burst_advance;
		bt = 2'h0;
		cur = a;
		lag = a;
		step(DES, 4'hf, a, '0);
		step(6'b011110, 4'hf, a, '0);
		step({2'b01, 1'($urandom), 3'b010}, 4'($urandom), a, '0);
		for (int k = 1; k <= 5; k++) begin
			burst_advance = 1'($urandom);
			step({2'b11, burst_advance, 3'b010}, 4'hf, pbs_addr_t'($urandom), '0);
			if (k == 1) look(1'b0, '0);
			else look(1'b1, mem[lag]);
			lag = cur;
			bt = bt + 2'(!burst_advance);
			cur = {a[16:2], burst_order_strap ? a[1:0] ^ bt : a[1:0] + bt};
		end
		step(DES, 4'hf, a, '0);
		look(1'b1, mem[lag]);
		step(DES, 4'hf, a, '0);
		look(1'b1, mem[cur]);
		step(DES, 4'hf, a, '0);
		look(1'b0, '0);
	endtask

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		pbs_addr_t a;
		pbs_word_t w;
		void'($urandom(4921));
		for (int m = 0; m < 2; m++) begin
			burst_order_strap = m[0];
			@(negedge clk);
			rstn = 1'b0;
			repeat (16) @(posedge clk);
			@(negedge clk);
			rstn = 1'b1;
			repeat (2) @(posedge clk);
			a = pbs_addr_t'($urandom);
			for (int k = 0; k < 4; k++) wr_controller_address_strobe({a[16:2], 2'(k)}, 4'b0111);
			for (int k = 0; k < 4; k++) wr_controller_address_strobe({a[16:2], 2'(k)}, {2'b10, 2'(k)});
			burst(a);
			$display("burst test with order strap %0d done", m);
		end
		w = pbs_word_t'($urandom);
		step(DES, 4'hf, a, '0);
		step({3'b010, 3'b010}, 4'h0, a, '0);
		step(6'b111010, 4'b0111, a, w);
		mem[a] = w;
		step(6'b110010, 4'b1010, a, ~w);
		a[1:0] = a[1:0] ^ 2'h1;
		mem[a] = mrg(mem[a], ~w, 4'b1010);
		burst(a);
		$display("processor strobe write test done");
		@(negedge clk);
		u_pbs_bus_master.nap(1'b1);
		repeat (2) step(IDL, 4'hf, a, '0);
		step(6'b100010, 4'b0111, a, ~mem[a]);
		look(1'b0, '0);
		step(6'b010010, 4'hf, a, '0);
		look(1'b0, '0);
		@(negedge clk);
		u_pbs_bus_master.nap(1'b0);
		repeat (`PBS_SLEEP_REC_CYC) step(IDL, 4'hf, a, '0);
		burst(a);
		$display("sleep test done");
		complete_run;
	end

	// the tests need about 110 cycles, so 4000 cycles means a hang
	initial begin
		repeat (4000) @(posedge clk);
		error_cnt++;
		complete_run;
	end
endmodule

`default_nettype wire
